// ### rtl/lp_ctrl.sv
// Overview of operation
// - Wait tXS equals tRFC1 plus 10ns
// - MR4 bit 9 selects abort mode
// - Abort mode shortens wait to tXS_ABORT
// - Extra REFRESH before next self refresh
// - NOP exit needs parity, CAL, gear-down off
// - Only NOP during tMPX_LH window
// - No power-down entry during busy operations
// - Reset DLL after unlocked power-down
// - DESELECT for tCPDED around CKE edges
// - Power-down exit is fast, tXP
// - CKE low tCKE, at most 9 tREFI
// - Exit on CKE high, hold tCKE, wait tXP
// - Drive ODT valid if RTT_NOM enabled
// - tPD minimum before raising CKE
// - Hold ODT fixed around CKE fall
// - DESELECT on every edge during tXS
`timescale 1ns/1ps
`default_nettype none
`include "lp_ctrl_defs.svh"
module lp_ctrl
    import lp_ctrl_pkg::*;
#(
    parameter int TRFC1_NS = `TRFC1_NS,
    parameter int TXS_ABORT_NS = `TXS_ABORT_NS,
    parameter int TXP_NS = `TXP_NS,
    parameter int TCKE_NS = `TCKE_NS,
    parameter int TMPX_LH_NS = `TMPX_LH_NS,
    parameter int TCPDED_CK = `TCPDED_CK,
    parameter int TDODTL_CK = `TDODTL_CK,
    // Power-down limit in cycles; a few thousand by default, so a bench may shorten it.
    parameter int PD_MAX_CK = (`PD_REFI_MULT * `TREFI_NS * 1000) / `CLK_PS
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // User requests.
    input wire logic i_sr_exit,
    input wire logic i_sr_exit_nop,
    input wire logic i_nop_ok,
    input wire logic i_sre_req,
    input wire logic i_ref_req,
    input wire logic i_pd_req,
    input wire logic i_pd_exit,
    input wire logic i_busy,
    input wire logic i_dll_locked,
    input wire logic i_odt_level,
    input wire logic i_dram_reset,
    // Mode register shadow write.
    input wire logic i_mr_we,
    input wire logic [2:0] i_mr_sel,
    input wire logic [17:0] i_mr_data,
    // Device pins.
    output logic o_cke,
    output logic o_reset_n,
    output logic o_odt,
    output logic o_odt_oe,
    output logic [2:0] o_cmd,
    // Status to the user.
    output logic o_cmd_ok,
    output logic o_dll_reset_req,
    output logic o_need_ref,
    output logic o_pd_timeout,
    output logic o_refused
);
    // Cycle counts derived from times; least times round up.
    localparam int TXS_CK = ((TRFC1_NS + `TXS_MARGIN_NS) * 1000 + `CLK_PS - 1) / `CLK_PS;
    localparam int TXSA_CK = (TXS_ABORT_NS * 1000 + `CLK_PS - 1) / `CLK_PS;
    localparam int TXP_CK = (TXP_NS * 1000 + `CLK_PS - 1) / `CLK_PS;
    localparam int TCKE_CK0 = (TCKE_NS * 1000 + `CLK_PS - 1) / `CLK_PS;
    // The CKE low time also covers tCPDED so receivers are off before exit.
    localparam int TCKE_CK = (TCKE_CK0 > TCPDED_CK) ? TCKE_CK0 : TCPDED_CK;
    localparam int TMPX_CK = (TMPX_LH_NS * 1000 + `CLK_PS - 1) / `CLK_PS;
    localparam int TW = 24;

    // Whole controller state.
    typedef struct packed {
        state_t st;
        logic cke;
        logic rst_n;
        logic odt;
        logic odt_oe;
        cmd_t cmd;
        logic cmd_ok;
        logic dll_rst;
        logic need_ref;
        logic pd_to;
        logic refused;
        logic nop_exit;
        logic [TW-1:0] pd_cnt;
        logic [7:0] des_cnt;
        logic [7:0] odt_age; // Cycles since the driven ODT level last changed.
    } ctl_t;
    ctl_t s_r, s_nxt;

    // Timer control and mode settings.
    logic t_load;
    logic [TW-1:0] t_count;
    logic t_done;
    logic abort_en;
    logic odtbuf_dis;
    logic rttnom_en;

    lp_timer #(.W(TW)) u_timer (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_load(t_load),
        .i_count(t_count),
        .o_done(t_done)
    );

    lp_mr_shadow u_mr (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_mr_we(i_mr_we),
        .i_mr_sel(i_mr_sel),
        .i_mr_data(i_mr_data),
        .o_abort_en(abort_en),
        .o_odtbuf_dis(odtbuf_dis),
        .o_rttnom_en(rttnom_en)
    );

    // Exit wait length for commands not needing a locked DLL.
    function automatic logic [TW-1:0] srx_wait(input logic ab);
        srx_wait = ab ? TW'(TXSA_CK) : TW'(TXS_CK);
    endfunction

    // Sequencer for self refresh exit and power-down.
    always_comb begin
        s_nxt = s_r;
        t_load = 1'b0;
        t_count = '0;
        s_nxt.refused = 1'b0;
        s_nxt.rst_n = ~i_dram_reset;
        // ODT is driven while termination may need it; it floats only where allowed.
        s_nxt.odt = i_odt_level;
        case (s_r.st)
            ST_IDLE: begin
                s_nxt.cmd = CMD_DES;
                s_nxt.odt_oe = 1'b1;
                if (i_ref_req && s_r.cke) begin
                    s_nxt.cmd = CMD_REF;
                    s_nxt.need_ref = 1'b0;
                end else if (i_sre_req) begin
                    // Re-entry refused until an extra refresh was sent.
                    if (s_r.need_ref || !s_r.cke) begin
                        s_nxt.refused = 1'b1;
                    end else begin
                        s_nxt.cmd = CMD_SRE;
                        s_nxt.cke = 1'b0;
                        s_nxt.cmd_ok = 1'b0;
                    end
                end else if ((i_sr_exit || i_sr_exit_nop) && !s_r.cke) begin
                    // NOP exit only when entry had parity, CAL and gear-down off.
                    s_nxt.nop_exit = i_sr_exit_nop && i_nop_ok;
                    s_nxt.refused = i_sr_exit_nop && !i_nop_ok;
                    s_nxt.cke = 1'b1;
                    s_nxt.need_ref = 1'b1;
                    s_nxt.st = ST_SRX;
                    t_load = 1'b1;
                    t_count = (i_sr_exit_nop && i_nop_ok) ? TW'(TMPX_CK) : srx_wait(abort_en);
                end else if (i_pd_req && s_r.cke) begin
                    if (i_busy) begin
                        s_nxt.refused = 1'b1;
                    end else if (s_r.odt_age < 8'(TDODTL_CK) || i_odt_level != s_r.odt) begin
                        // A fresh ODT level could be cut mid-window by CKE falling, so refuse.
                        s_nxt.refused = 1'b1;
                    end else begin
                        // Unlocked DLL at entry calls for a DLL reset later.
                        s_nxt.dll_rst = ~i_dll_locked;
                        s_nxt.cke = 1'b0;
                        s_nxt.cmd_ok = 1'b0;
                        s_nxt.pd_cnt = '0;
                        s_nxt.des_cnt = '0;
                        s_nxt.st = ST_PDE;
                        t_load = 1'b1;
                        t_count = TW'(TCKE_CK);
                    end
                end
            end
            ST_SRX: begin
                // NOP window first, then the tXS style wait with DESELECT.
                s_nxt.cmd = s_r.nop_exit ? CMD_NOP : CMD_DES;
                s_nxt.odt = 1'b0;
                if (t_done) begin
                    if (s_r.nop_exit) begin
                        s_nxt.nop_exit = 1'b0;
                        s_nxt.cmd = CMD_DES;
                        t_load = 1'b1;
                        t_count = srx_wait(abort_en);
                    end else begin
                        s_nxt.st = ST_SRX_WAIT;
                    end
                end
            end
            ST_SRX_WAIT: begin
                // One settling cycle before user commands are released again.
                s_nxt.cmd = CMD_DES;
                s_nxt.cmd_ok = 1'b1;
                s_nxt.st = ST_IDLE;
            end
            ST_PDE: begin
                // DESELECT held and ODT held fixed through tCPDED after CKE fall.
                s_nxt.cmd = CMD_DES;
                s_nxt.odt_oe = 1'b1;
                s_nxt.odt = s_r.odt;
                s_nxt.pd_cnt = s_r.pd_cnt + TW'(1);
                if (s_r.des_cnt < 8'(TCPDED_CK)) begin
                    s_nxt.des_cnt = s_r.des_cnt + 8'h01;
                end
                if (t_done && s_r.des_cnt >= 8'(TCPDED_CK)) begin
                    s_nxt.st = ST_PD;
                end
            end
            ST_PD: begin
                s_nxt.cmd = CMD_DES;
                // Float ODT only with the buffer disabled and RTT_NOM off.
                s_nxt.odt_oe = !(odtbuf_dis && !rttnom_en);
                s_nxt.pd_cnt = s_r.pd_cnt + TW'(1);
                // The refresh budget has run out: leave on our own and flag it.
                if (s_r.pd_cnt >= TW'(PD_MAX_CK - 1)) begin
                    s_nxt.pd_to = 1'b1;
                end
                if (i_pd_exit || s_r.pd_cnt >= TW'(PD_MAX_CK - 1)) begin
                    s_nxt.cke = 1'b1;
                    s_nxt.odt_oe = 1'b1;
                    s_nxt.des_cnt = '0;
                    s_nxt.st = ST_PDX;
                    t_load = 1'b1;
                    t_count = TW'((TCKE_CK > TXP_CK) ? TCKE_CK : TXP_CK);
                end
            end
            ST_PDX: begin
                s_nxt.cmd = CMD_DES;
                s_nxt.odt_oe = 1'b1;
                if (s_r.des_cnt < 8'(TCPDED_CK)) begin
                    s_nxt.des_cnt = s_r.des_cnt + 8'h01;
                end
                if (t_done && s_r.des_cnt >= 8'(TCPDED_CK)) begin
                    s_nxt.st = ST_PDX_WAIT;
                end
            end
            ST_PDX_WAIT: begin
                // One settling cycle after tXP before commands are allowed.
                s_nxt.cmd = CMD_DES;
                s_nxt.cmd_ok = 1'b1;
                s_nxt.st = ST_IDLE;
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
        if (s_r.st == ST_IDLE && s_r.cmd_ok && s_r.cke) begin
            s_nxt.cmd = (i_ref_req) ? CMD_REF : s_nxt.cmd;
        end
        if (s_r.st == ST_IDLE && s_r.dll_rst && s_r.cmd_ok && i_dll_locked) begin
            s_nxt.dll_rst = 1'b0;
        end
        // Age of the ODT level last driven; power-down entry needs it settled.
        if (s_nxt.odt != s_r.odt) begin
            s_nxt.odt_age = '0;
        end else if (s_r.odt_age != 8'hFF) begin
            s_nxt.odt_age = s_r.odt_age + 8'h01;
        end
        // DRAM reset drives the device into its reset state from any state.
        if (i_dram_reset) begin
            s_nxt.st = ST_IDLE;
            s_nxt.cke = 1'b0;
            s_nxt.cmd = CMD_DES;
            s_nxt.cmd_ok = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_r <= '{st: ST_IDLE, cke: 1'b1, rst_n: 1'b1, odt: 1'b0, odt_oe: 1'b1,
                cmd: CMD_DES, cmd_ok: 1'b1, dll_rst: 1'b0, need_ref: 1'b0,
                pd_to: 1'b0, refused: 1'b0, nop_exit: 1'b0, pd_cnt: '0, des_cnt: '0,
                odt_age: 8'hFF};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_cke = s_r.cke;
    assign o_reset_n = s_r.rst_n;
    assign o_odt = s_r.odt;
    assign o_odt_oe = s_r.odt_oe;
    assign o_cmd = s_r.cmd;
    assign o_cmd_ok = s_r.cmd_ok;
    assign o_dll_reset_req = s_r.dll_rst;
    assign o_need_ref = s_r.need_ref;
    assign o_pd_timeout = s_r.pd_to;
    assign o_refused = s_r.refused;
endmodule
`default_nettype wire

// ### rtl/lp_ctrl_defs.svh
`ifndef LP_CTRL_DEFS_SVH
`define LP_CTRL_DEFS_SVH
// Clock period of i_sys_clk in picoseconds.
`define CLK_PS 20000
// Margin added to tRFC1 to form the self refresh exit time, in ns.
`define TXS_MARGIN_NS 10
// Default tRFC1 in ns.
`define TRFC1_NS 350
// Default tXS_ABORT in ns.
`define TXS_ABORT_NS 50
// Default tXP in ns.
`define TXP_NS 8
// Default tCKE (and tPD) minimum in ns.
`define TCKE_NS 8
// Default tMPX_LH in ns.
`define TMPX_LH_NS 20
// Default tREFI in ns.
`define TREFI_NS 7800
// Power-down limit as a multiple of tREFI.
`define PD_REFI_MULT 9
// Default tCPDED in clock cycles.
`define TCPDED_CK 4
// Default tDODTLoff plus one, in clock cycles.
`define TDODTL_CK 8
// Mode register bit positions.
`define MR4_ABORT_BIT 9
`define MR5_ODTBUF_BIT 5
`define MR1_RTTNOM_HI 10
`define MR1_RTTNOM_LO 8
`endif

// ### rtl/lp_ctrl_pkg.sv
package lp_ctrl_pkg;
    // Command codes presented on the command bus.
    typedef enum logic [2:0] {
        CMD_DES = 3'h0,
        CMD_NOP = 3'h1,
        CMD_REF = 3'h2,
        CMD_SRE = 3'h3,
        CMD_USER = 3'h4
    } cmd_t;
    // Controller states, one-hot.
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_SRX = 7'h02,
        ST_SRX_WAIT = 7'h04,
        ST_PDE = 7'h08,
        ST_PD = 7'h10,
        ST_PDX = 7'h20,
        ST_PDX_WAIT = 7'h40
    } state_t;
endpackage

// ### rtl/lp_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Down counter used for every exit wait; done is registered.
module lp_timer #(
    parameter int W = 24
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Load and status.
    input wire logic i_load,
    input wire logic [W-1:0] i_count,
    output logic o_done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } tmr_t;
    tmr_t s_r, s_nxt;
    // Counting down to one raises done on the following edge.
    always_comb begin
        s_nxt = s_r;
        if (i_load) begin
            s_nxt.cnt = i_count;
            s_nxt.done = 1'b0;
        end else if (s_r.cnt > W'(1)) begin
            s_nxt.cnt = s_r.cnt - W'(1);
        end else begin
            s_nxt.cnt = '0;
            s_nxt.done = 1'b1;
        end
    end
    // State register.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign o_done = s_r.done;
endmodule
`default_nettype wire

// ### rtl/lp_mr_shadow.sv
`timescale 1ns/1ps
`default_nettype none
`include "lp_ctrl_defs.svh"
// Shadow of the mode register fields that steer low-power timing.
module lp_mr_shadow (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Mode register write from the user side.
    input wire logic i_mr_we,
    input wire logic [2:0] i_mr_sel,
    input wire logic [17:0] i_mr_data,
    // Decoded settings.
    output logic o_abort_en,
    output logic o_odtbuf_dis,
    output logic o_rttnom_en
);
    typedef struct packed {
        logic abort_en;
        logic odtbuf_dis;
        logic rttnom_en;
    } mr_t;
    mr_t s_r, s_nxt;
    // Capture the bits when the matching register is written.
    always_comb begin
        s_nxt = s_r;
        if (i_mr_we) begin
            case (i_mr_sel)
                3'h1: s_nxt.rttnom_en = |i_mr_data[`MR1_RTTNOM_HI:`MR1_RTTNOM_LO];
                3'h4: s_nxt.abort_en = i_mr_data[`MR4_ABORT_BIT];
                3'h5: s_nxt.odtbuf_dis = i_mr_data[`MR5_ODTBUF_BIT];
                default: s_nxt = s_r;
            endcase
        end
    end
    // State register.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign o_abort_en = s_r.abort_en;
    assign o_odtbuf_dis = s_r.odtbuf_dis;
    assign o_rttnom_en = s_r.rttnom_en;
endmodule
`default_nettype wire

// ### tb/lp_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the low-power controller; bound below.
module lp_ctrl_properties
    import lp_ctrl_pkg::*;
#(
    parameter int TRFC1_NS = 350,
    parameter int TXS_ABORT_NS = 50,
    parameter int PD_MAX_CK = 200
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_sre_req,
    input wire logic i_ref_req,
    input wire logic i_pd_req,
    input wire logic i_busy,
    input wire logic i_dll_locked,
    input wire logic i_mr_we,
    input wire logic [2:0] i_mr_sel,
    input wire logic [17:0] i_mr_data,
    input wire logic o_cke,
    input wire logic o_reset_n,
    input wire logic o_odt,
    input wire logic o_odt_oe,
    input wire logic [2:0] o_cmd,
    input wire logic o_cmd_ok,
    input wire logic o_dll_reset_req,
    input wire logic o_need_ref,
    input wire logic o_refused
);
    // Exit waits in 20 ns cycles, rounded up.
    localparam int TXS_CK = (TRFC1_NS + 10 + 19) / 20;
    localparam int TXSA_CK = (TXS_ABORT_NS + 19) / 20;
    localparam int PD_LIM = PD_MAX_CK + 8;
    logic in_sr_r;
    logic abort_r;
    logic dll_r;
    int hi_r;
    int lo_r;
    // Tracks the abort bit, self refresh residence, the length of each CKE low phase and of each exit wait.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            in_sr_r <= 1'b0;
            abort_r <= 1'b0;
            dll_r <= 1'b1;
            hi_r <= 0;
            lo_r <= 0;
        end else begin
            if (i_mr_we && i_mr_sel == 3'h4) begin
                abort_r <= i_mr_data[9];
            end
            if (o_cmd == CMD_SRE) begin
                in_sr_r <= 1'b1;
            end else if (o_cke && o_cmd_ok) begin
                in_sr_r <= 1'b0;
            end
            if (o_cke && o_cmd_ok) begin
                dll_r <= i_dll_locked;
            end
            hi_r <= (o_cke && !o_cmd_ok) ? hi_r + 1 : 0;
            lo_r <= o_cke ? 0 : lo_r + 1;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    // Deselects and a steady ODT are owed while the CKE edge propagates.
    sequence s_des4;
        (o_cmd == CMD_DES) [*4];
    endsequence
    sequence s_odt4;
        (o_odt_oe && $stable(o_odt)) [*4];
    endsequence
    AST_TXS_MIN: assert property (
        $rose(o_cmd_ok) && in_sr_r |-> hi_r >= (abort_r ? TXSA_CK : TXS_CK))
        else $error("self refresh exit released commands too early");
    AST_EXIT_CMDS: assert property (
        o_cke && !o_cmd_ok |-> o_cmd inside {CMD_DES, CMD_NOP})
        else $error("command other than deselect or nop during exit");
    AST_ENTRY_DES: assert property (
        $fell(o_cke) && o_cmd != CMD_SRE && o_reset_n |-> s_des4)
        else $error("deselects missing after power-down entry");
    AST_ODT_HOLD: assert property (
        $fell(o_cke) && o_cmd != CMD_SRE && o_reset_n |-> s_odt4)
        else $error("odt not held around power-down entry");
    AST_NEED_REF: assert property (
        $rose(o_cke) && in_sr_r |-> o_need_ref)
        else $error("extra refresh not owed after self refresh exit");
    AST_SRE_REFUSE: assert property (
        o_need_ref && i_sre_req && !i_ref_req && o_cmd_ok |=> o_refused && o_cmd != CMD_SRE)
        else $error("self refresh entered before the extra refresh");
    AST_BUSY_PD: assert property (
        i_busy && i_pd_req && !i_ref_req && !i_sre_req && o_cmd_ok |=> o_cke && o_refused)
        else $error("cke dropped during a busy operation");
    AST_PD_LIMIT: assert property (
        !o_cke && !in_sr_r && o_reset_n |-> lo_r <= PD_LIM)
        else $error("power-down held beyond its limit");
    AST_DLL_RST: assert property (
        $rose(o_cmd_ok) && !in_sr_r && !dll_r |-> ##[0:4] o_dll_reset_req)
        else $error("dll reset not requested after unlocked power-down");
endmodule
bind lp_ctrl lp_ctrl_properties #(.TRFC1_NS(TRFC1_NS), .TXS_ABORT_NS(TXS_ABORT_NS),
    .PD_MAX_CK(PD_MAX_CK)) i_lp_ctrl_properties (.*);
`default_nettype wire

// ### tb/ddr_lp_device.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural memory device: follows CKE and the command bus and flags misuse.
module ddr_lp_device
    import lp_ctrl_pkg::*;
(
    // Pins from the controller.
    input wire logic i_ck,
    input wire logic i_reset_n,
    input wire logic i_cke,
    input wire logic [2:0] i_cmd,
    input wire logic i_odt_oe,
    // Mode settings as last written.
    input wire logic i_abort_en,
    input wire logic i_odtbuf_dis,
    // State seen by the bench.
    output logic o_pd,
    output logic o_sr,
    output logic [7:0] o_refs,
    output logic o_bad
);
    logic cke_q;
    logic [2:0] dly;
    // The device acts on rising CK only; reset leaves any low-power state.
    always_ff @(posedge i_ck or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pd <= 1'b0;
            o_sr <= 1'b0;
            o_refs <= 8'h00;
            o_bad <= 1'b0;
            cke_q <= 1'b1;
            dly <= 3'h4;
        end else begin
            cke_q <= i_cke;
            dly <= (dly != 3'h4) ? dly + 3'h1 : dly;
            if (i_cmd == CMD_REF && i_cke) begin
                o_refs <= o_refs + 8'h01;
            end
            // CKE low with DES gives power-down, precharge or active alike.
            if (cke_q && !i_cke) begin
                dly <= 3'h0;
                o_pd <= (i_cmd == CMD_DES);
                o_sr <= (i_cmd == CMD_SRE);
            end
            // CKE high leaves at once since the DLL stayed on.
            if (!cke_q && i_cke) begin
                o_pd <= 1'b0;
                o_sr <= 1'b0;
                o_bad <= o_bad | !(i_cmd inside {CMD_DES, CMD_NOP});
                // An aborted internal refresh does not count.
                if (o_sr && !i_abort_en) begin
                    o_refs <= o_refs + 8'h01;
                end
            end
            // Receivers stay on through tCPDED, so only DES is taken.
            if (o_pd && dly < 3'h4 && i_cmd != CMD_DES) begin
                o_bad <= 1'b1;
            end
            // ODT floats only in self refresh, or in power-down with its buffer off after tCPDED; park stays on.
            if (!i_odt_oe && !o_sr && !(o_pd && i_odtbuf_dis && dly == 3'h4)) begin
                o_bad <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/test_lp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the low-power controller against the behavioural device.
module test_lp_ctrl
    import lp_ctrl_pkg::*;
;
    localparam int PD_MAX = 200;
    localparam int TXS_CK = (350 + 10 + 19) / 20;
    localparam int TXSA_CK = (50 + 19) / 20;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [5:0] rq = 6'h00;
    logic nop_ok = 1'b0;
    logic busy = 1'b0;
    logic dll = 1'b1;
    logic odt = 1'b0;
    logic dram_rst = 1'b0;
    logic mr_we = 1'b0;
    logic [2:0] mr_sel = 3'h0;
    logic [17:0] mr_data = 18'h00000;
    logic abort_en = 1'b0;
    logic odtbuf_dis = 1'b0;
    wire logic cke, reset_n, odt_q, odt_oe, cmd_ok, dll_rr, need_ref, pd_to, refused;
    wire logic [2:0] cmd;
    wire logic dev_pd, dev_sr, dev_bad;
    wire logic [7:0] dev_refs;
    int failures = 0;
    int checks = 0;
    int seed = 21;
    int cyc = 0;
    int n;
    int exp_refs = 0;
    lp_ctrl #(.PD_MAX_CK(PD_MAX)) i_lp_ctrl (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
        .i_sr_exit(rq[0]), .i_sr_exit_nop(rq[1]), .i_nop_ok(nop_ok), .i_sre_req(rq[2]),
        .i_ref_req(rq[3]), .i_pd_req(rq[4]), .i_pd_exit(rq[5]), .i_busy(busy),
        .i_dll_locked(dll), .i_odt_level(odt), .i_dram_reset(dram_rst), .i_mr_we(mr_we),
        .i_mr_sel(mr_sel), .i_mr_data(mr_data), .o_cke(cke), .o_reset_n(reset_n),
        .o_odt(odt_q), .o_odt_oe(odt_oe), .o_cmd(cmd), .o_cmd_ok(cmd_ok),
        .o_dll_reset_req(dll_rr), .o_need_ref(need_ref), .o_pd_timeout(pd_to),
        .o_refused(refused));
    ddr_lp_device i_ddr_lp_device (.i_ck(i_sys_clk), .i_reset_n(i_rstn && reset_n),
        .i_cke(cke), .i_cmd(cmd), .i_odt_oe(odt_oe), .i_abort_en(abort_en),
        .i_odtbuf_dis(odtbuf_dis), .o_pd(dev_pd), .o_sr(dev_sr), .o_refs(dev_refs),
        .o_bad(dev_bad));
    always #10 i_sys_clk = ~i_sys_clk;
    // A hang is cut short well above the few hundred cycles the run needs.
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end
    // Compares one value and counts the outcome.
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One-cycle request pulse; returns once the answer has settled.
    task req(input int b);
        @(posedge i_sys_clk);
        rq <= 6'h01 << b;
        @(posedge i_sys_clk);
        rq <= 6'h00;
        @(negedge i_sys_clk);
    endtask
    task mr(input logic [2:0] sel, input logic [17:0] d);
        @(posedge i_sys_clk);
        mr_we <= 1'b1;
        mr_sel <= sel;
        mr_data <= d;
        @(posedge i_sys_clk);
        mr_we <= 1'b0;
    endtask
    // Counts cycles until commands are allowed again, bounded.
    task wait_ok();
        n = 0;
        while (cmd_ok !== 1'b1 && n < 400) begin
            @(negedge i_sys_clk);
            n++;
        end
    endtask
    function int exit_min(input logic ab);
        return ab ? TXSA_CK : TXS_CK;
    endfunction
    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        @(negedge i_sys_clk);
        chk(32'({cke, reset_n, odt_oe, cmd_ok, cmd}), 32'({4'hF, CMD_DES}));
        // Self refresh exit with the abort bit off, then on, random bits above it.
        for (int ab = 0; ab < 2; ab++) begin
            mr(3'h4, {8'($random(seed)), ab[0], 9'h000});
            abort_en <= ab[0];
            req(2);
            repeat (4 + ($random(seed) & 7)) @(negedge i_sys_clk);
            chk(32'({cke, dev_sr}), 32'h1);
            req(0);
            chk(32'({cke, need_ref}), 32'h3);
            wait_ok();
            chk(32'(n >= exit_min(ab[0]) && n <= exit_min(ab[0]) + 6), 32'h1);
            exp_refs += ab ? 0 : 1;
            req(2);
            chk(32'({refused, cke}), 32'h3);
            req(3);
            exp_refs++;
            wait_ok();
            @(negedge i_sys_clk);
            chk(32'({need_ref, dev_refs}), 32'({1'b0, 8'(exp_refs)}));
            $display("self refresh exit done, abort %0d", ab);
        end
        // Exit by NOP is refused unless entry had parity, CAL and gear-down off.
        for (int k = 0; k < 2; k++) begin
            @(posedge i_sys_clk);
            nop_ok <= k[0];
            req(2);
            repeat (4) @(negedge i_sys_clk);
            req(1);
            chk(32'(refused), 32'(!k[0]));
            wait_ok();
            req(3);
            exp_refs++;
            wait_ok();
            $display("nop exit done, allowed %0d", k);
        end
        @(posedge i_sys_clk);
        busy <= 1'b1;
        req(4);
        chk(32'({refused, cke}), 32'h3);
        @(posedge i_sys_clk);
        busy <= 1'b0;
        // ODT buffer off in power-down with RTT_NOM off, so ODT may float.
        mr(3'h5, 18'h00020);
        mr(3'h1, 18'h00000);
        odtbuf_dis <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            @(posedge i_sys_clk);
            dll <= !k[0];
            odt <= !odt;
            // A freshly changed ODT level must not be cut by CKE falling.
            req(4);
            chk(32'({refused, cke}), 32'h3);
            repeat (10) @(posedge i_sys_clk);
            req(4);
            // ODT changes right after entry; the pin must keep the old level.
            @(posedge i_sys_clk);
            odt <= !odt;
            repeat (2) @(negedge i_sys_clk);
            chk(32'(odt_q), 32'(!odt));
            repeat (10 + ($random(seed) & 15)) @(negedge i_sys_clk);
            chk(32'({cke, dev_pd}), 32'h1);
            req(5);
            wait_ok();
            chk(32'(n <= 8), 32'h1);
            chk(32'({dev_pd, dll_rr}), 32'({1'b0, k[0]}));
            $display("power-down exit done, dll unlocked %0d", k);
        end
        // Left in power-down, the controller must leave by itself.
        req(4);
        n = 0;
        while (cke !== 1'b1 && n < PD_MAX + 50) begin
            @(negedge i_sys_clk);
            n++;
        end
        chk({pd_to, 31'(n <= PD_MAX + 8)}, 32'h80000001);
        wait_ok();
        chk(32'({dev_bad, dev_refs}), 32'({1'b0, 8'(exp_refs)}));
        // Once the DLL locks again the reset request is withdrawn.
        @(posedge i_sys_clk);
        dll <= 1'b1;
        repeat (2) @(negedge i_sys_clk);
        chk(32'(dll_rr), 32'h0);
        @(posedge i_sys_clk);
        dram_rst <= 1'b1;
        repeat (3) @(negedge i_sys_clk);
        chk(32'({reset_n, dev_pd, dev_sr}), 32'h0);
        $display("device reset done");
        results();
    end
endmodule
`default_nettype wire
